// ==== src/pwsf_framer.sv ====
// Receive side of the pseudowire sub-layer: header parse, segment reassembly, probe replies.
// Assumes inputs synchronous to mclk and a session type fixed while session_open is high.
`timescale 1ns/10ps

module pwsf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr;
  logic [AW:0]      rd;
  logic [AW:0]      next_wr;
  logic [AW:0]      next_rd;

  always_comb begin
    in_ready  = !((wr[AW] != rd[AW]) && (wr[AW-1:0] == rd[AW-1:0]));
    out_valid = (wr != rd);
    out_data  = mem[rd[AW-1:0]];
    next_wr   = wr + (AW+1)'(in_valid && in_ready);
    next_rd   = rd + (AW+1)'(out_valid && out_ready);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr <= '0;
      rd <= '0;
    end else begin
      wr <= next_wr;
      rd <= next_rd;
    end
  end

  // The storage has no reset; only the pointers say what is valid.
  always_ff @(posedge mclk) begin
    if (in_valid && in_ready) begin
      mem[wr[AW-1:0]] <= in_data;
    end
  end
endmodule

module pwsf_framer
  import pwsf_pkg::*;
(
  // Clock and reset
  input  wire logic     mclk,
  input  wire logic     arst_n,
  // Session configuration
  input  wire logic     session_open,
  input  wire logic     session_streaming,
  input  wire logic     egress_supported,
  // Tunnel payload bytes
  input  wire logic     rx_valid,
  output logic          rx_ready,
  input  wire logic [7:0] rx_data,
  input  wire logic     rx_last,
  // Parsed payload
  output logic          out_valid,
  input  wire logic     out_ready,
  output pwsf_item_type out_item,
  // Probe replies
  output logic          reply_valid,
  output pwsf_reply_type reply,
  // Status
  output logic          seq_gap,
  output logic          hdr_drop,
  output logic          frame_err,
  output logic          teardown_req
);
  pwsf_state_type state, next_state;
  logic           numv, next_numv;
  logic           probe, next_probe;
  logic [2:0]     tag, next_tag;
  logic [2:0]     locked_tag, next_locked_tag;
  logic           tag_locked, next_tag_locked;
  logic [7:0]     hold, next_hold;
  logic [15:0]    exp_seq, next_exp_seq;
  logic           seq_seen, next_seq_seen;
  logic [6:0]     tally, next_tally;
  logic [6:0]     tbl_cnt, next_tbl_cnt;
  logic [6:0]     seg_idx, next_seg_idx;
  logic [13:0]    seg_pos, next_seg_pos;
  logic [7:0]     ts_cnt, next_ts_cnt;
  logic [PID_MSB:0] pid_hi, next_pid_hi;
  logic           is_null, next_is_null;
  logic           in_frame, next_in_frame;
  logic [7:0]     probe_code, next_probe_code;
  logic           next_reply_valid, next_seq_gap, next_hdr_drop, next_frame_err;
  logic           next_teardown;
  pwsf_reply_type next_reply;
  logic [15:0]    seg_table [MAX_SEGS];
  logic [15:0]    entry, rx_word;
  logic [1:0]     ext;
  logic           accept, push, tbl_we, seg_last, fifo_ready;
  pwsf_item_type  item;
  logic [$bits(pwsf_item_type)-1:0] fifo_q;

  // ----------------------------------------------------------------
  // Parser
  // ----------------------------------------------------------------
  assign entry   = seg_table[seg_idx];
  assign rx_word = {hold, rx_data};
  assign ext     = rx_data[EXT_HI:EXT_LO];
  assign accept  = rx_valid && rx_ready;

  always_comb begin
    next_state = state;  next_numv = numv;  next_probe = probe;  next_tag = tag;
    next_locked_tag = locked_tag;  next_tag_locked = tag_locked;  next_hold = hold;
    next_exp_seq = exp_seq;  next_seq_seen = seq_seen;  next_tally = tally;
    next_tbl_cnt = tbl_cnt;  next_seg_idx = seg_idx;  next_seg_pos = seg_pos;
    next_ts_cnt = ts_cnt;  next_pid_hi = pid_hi;  next_is_null = is_null;
    next_in_frame = in_frame;  next_probe_code = probe_code;  next_reply = reply;
    next_teardown = teardown_req;
    next_reply_valid = 1'b0;  next_seq_gap = 1'b0;
    next_hdr_drop = 1'b0;  next_frame_err = 1'b0;
    push = 1'b0;  tbl_we = 1'b0;  item = '0;
    item.data = rx_data;  item.tag = tag;  item.streaming = session_streaming;
    seg_last = (seg_pos + 14'h0001) == entry[ENT_LEN_HI:0];
    rx_ready = (state == ST_PAYLOAD) ? fifo_ready : 1'b1;
    if (accept) begin
      case (state)
        ST_HDR0: begin
          // The spare bit is never looked at.
          next_numv  = rx_data[NUMV_BIT];
          next_tag   = rx_data[TAG_HI:TAG_LO];
          next_probe = (ext == EXT_PROBE);
          if (!session_open || rx_data[CHECK_BIT] || ext[1]
              || (ext == EXT_PROBE && rx_data[NUMV_BIT])) begin
            next_hdr_drop = 1'b1;
            next_state    = rx_last ? ST_HDR0 : ST_DROP;
          end else if (rx_last) begin
            next_hdr_drop = 1'b1;
          end else begin
            next_state = ST_HDR1;
          end
        end
        ST_HDR1: begin
          // Reserved byte content is ignored in both non-streaming layouts.
          if (probe) begin
            next_state = ST_PCODE;
          end else if (session_streaming) begin
            next_tally = rx_data[TALLY_HI:0];
            next_state = ST_SEQ0;
            if (rx_data[TALLY_HI:0] == '0) begin
              next_hdr_drop = 1'b1;
              next_state    = ST_DROP;
            end
          end else begin
            next_state = ST_SEQ0;
          end
        end
        ST_SEQ0: begin
          next_hold  = rx_data;
          next_state = ST_SEQ1;
        end
        ST_SEQ1: begin
          if (numv) begin
            next_seq_gap  = seq_seen && (rx_word != exp_seq);
            next_exp_seq  = rx_word + 16'h0001;
            next_seq_seen = 1'b1;
          end
          next_tbl_cnt = '0;
          next_ts_cnt  = TS_FIRST;
          next_seg_idx = '0;
          next_seg_pos = '0;
          if (session_streaming) begin
            next_state = ST_TBL_HI;
          end else if (tag_locked && tag != locked_tag) begin
            next_state = ST_DROP;
          end else begin
            next_locked_tag = tag;
            next_tag_locked = 1'b1;
            next_state      = ST_PAYLOAD;
          end
        end
        ST_TBL_HI: begin
          next_hold  = rx_data;
          next_state = ST_TBL_LO;
        end
        ST_TBL_LO: begin
          if (rx_word[ENT_LEN_HI:0] == '0) begin
            next_hdr_drop = 1'b1;
            next_state    = ST_DROP;
          end else begin
            tbl_we       = 1'b1;
            next_tbl_cnt = tbl_cnt + 7'h01;
            next_state   = (tbl_cnt + 7'h01 == tally) ? ST_PAYLOAD : ST_TBL_HI;
          end
        end
        ST_PAYLOAD: begin
          push = 1'b1;
          if (session_streaming) begin
            item.seg_first   = (seg_pos == '0);
            item.seg_last    = seg_last;
            item.frame_start = item.seg_first && entry[ENT_START_BIT];
            item.frame_end   = seg_last && entry[ENT_TAIL_BIT];
            if (item.seg_first) begin
              // A middle piece with no open frame, or a new start over one, is lost data.
              next_frame_err = entry[ENT_START_BIT] ? in_frame : !in_frame;
              next_in_frame  = 1'b1;
            end
            if (item.frame_end) begin
              next_in_frame = 1'b0;
            end
            next_seg_pos = seg_last ? '0 : seg_pos + 14'h0001;
            if (seg_last) begin
              next_seg_idx = seg_idx + 7'h01;
              if (seg_idx + 7'h01 == tally) begin
                next_frame_err = next_frame_err || !rx_last;
                next_state     = rx_last ? ST_HDR0 : ST_DROP;
              end
            end
            if (rx_last && !(seg_last && seg_idx + 7'h01 == tally)) begin
              next_frame_err = 1'b1;
              next_state     = ST_HDR0;
            end
          end else begin
            item.seg_first = (ts_cnt == TS_FIRST);
            item.seg_last  = (ts_cnt == TS_LAST);
            item.null_pkt  = is_null;
            if (ts_cnt == TS_PID_HI) begin
              next_pid_hi = rx_data[PID_MSB:0];
            end
            if (ts_cnt == TS_PID_LO) begin
              next_is_null = ({pid_hi, rx_data} == NULL_PID);
              item.null_pkt = next_is_null;
            end
            // Any count of whole packets is taken; the wrap starts the next one.
            next_ts_cnt = (ts_cnt == TS_LAST) ? TS_FIRST : ts_cnt + 8'h01;
            if (rx_last) begin
              // A length that is not whole packets means a streaming-type sender.
              next_teardown = next_teardown || (ts_cnt != TS_LAST);
              next_state    = ST_HDR0;
            end
          end
        end
        ST_PCODE: begin
          next_probe_code = rx_data;
          next_state      = ST_PTXN;
        end
        ST_PTXN: begin
          next_reply.txn = rx_data;
          next_reply.tag = tag;
          next_state     = ST_PTAIL;
        end
        ST_PTAIL: begin
          // Timestamps pass by; the reply waits for the whole probe.
          if (rx_last) begin
            next_state = ST_HDR0;
            if (probe_code == CODE_IN_REQ) begin
              next_reply_valid = 1'b1;
              next_reply.code  = CODE_IN_REP;
            end else if (probe_code == CODE_EG_REQ && egress_supported) begin
              next_reply_valid = 1'b1;
              next_reply.code  = CODE_EG_REP;
            end
          end
        end
        ST_DROP: begin
          if (rx_last) begin
            next_state = ST_HDR0;
          end
        end
        default: next_state = ST_HDR0;
      endcase
      // A payload that ends inside the header is malformed.
      if (rx_last && state inside {ST_HDR1, ST_SEQ0, ST_SEQ1, ST_TBL_HI,
                                   ST_TBL_LO, ST_PCODE, ST_PTXN}) begin
        next_hdr_drop    = 1'b1;
        next_state       = ST_HDR0;
        next_reply_valid = 1'b0;
      end
    end
    if (!session_open) begin
      next_teardown   = 1'b0;
      next_tag_locked = 1'b0;
      next_seq_seen   = 1'b0;
      next_in_frame   = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_HDR0;  numv <= 1'b0;  probe <= 1'b0;  tag <= '0;
      locked_tag <= '0;  tag_locked <= 1'b0;  hold <= '0;  exp_seq <= '0;
      seq_seen <= 1'b0;  tally <= '0;  tbl_cnt <= '0;  seg_idx <= '0;
      seg_pos <= '0;  ts_cnt <= '0;  pid_hi <= '0;  is_null <= 1'b0;
      in_frame <= 1'b0;  probe_code <= '0;  reply <= '0;  reply_valid <= 1'b0;
      seq_gap <= 1'b0;  hdr_drop <= 1'b0;  frame_err <= 1'b0;  teardown_req <= 1'b0;
    end else begin
      state <= next_state;  numv <= next_numv;  probe <= next_probe;  tag <= next_tag;
      locked_tag <= next_locked_tag;  tag_locked <= next_tag_locked;  hold <= next_hold;
      exp_seq <= next_exp_seq;  seq_seen <= next_seq_seen;  tally <= next_tally;
      tbl_cnt <= next_tbl_cnt;  seg_idx <= next_seg_idx;  seg_pos <= next_seg_pos;
      ts_cnt <= next_ts_cnt;  pid_hi <= next_pid_hi;  is_null <= next_is_null;
      in_frame <= next_in_frame;  probe_code <= next_probe_code;  reply <= next_reply;
      reply_valid <= next_reply_valid;  seq_gap <= next_seq_gap;
      hdr_drop <= next_hdr_drop;  frame_err <= next_frame_err;  teardown_req <= next_teardown;
    end
  end

  always_ff @(posedge mclk) begin
    if (tbl_we) begin
      seg_table[tbl_cnt] <= rx_word;
    end
  end

  // ----------------------------------------------------------------
  // Payload buffer
  // ----------------------------------------------------------------
  // Bytes already queued stay queued if a later check fails; flags tell the sink.
  pwsf_fifo #(.WIDTH($bits(pwsf_item_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (item),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_q)
  );
  assign out_item = pwsf_item_type'(fifo_q);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_check_drop;
    accept && state == ST_HDR0 && rx_data[CHECK_BIT] |=> hdr_drop ##1 !reply_valid;
  endproperty
  a_check_drop: assert property (p_check_drop) else $error("check flag not dropped");

  property p_ext_bad;
    accept && state == ST_HDR0 && ext[1] && !rx_last |=> hdr_drop && state == ST_DROP;
  endproperty
  a_ext_bad: assert property (p_ext_bad) else $error("bad extension kind kept");

  property p_probe_numv;
    accept && state == ST_HDR0 && ext == EXT_PROBE && rx_data[NUMV_BIT] |=> hdr_drop;
  endproperty
  a_probe_numv: assert property (p_probe_numv) else $error("numbered probe kept");

  property p_in_reply;
    accept && state == ST_PTAIL && rx_last && probe_code == CODE_IN_REQ
      |=> reply_valid && reply.code == CODE_IN_REP && reply.txn == $past(reply.txn);
  endproperty
  a_in_reply: assert property (p_in_reply) else $error("ingress reply missing");

  property p_eg_reply;
    accept && state == ST_PTAIL && rx_last && probe_code == CODE_EG_REQ && egress_supported
      |=> reply_valid && reply.code == CODE_EG_REP;
  endproperty
  a_eg_reply: assert property (p_eg_reply) else $error("egress reply missing");

  property p_eg_discard;
    accept && state == ST_PTAIL && probe_code == CODE_EG_REQ && !egress_supported
      |=> !reply_valid;
  endproperty
  a_eg_discard: assert property (p_eg_discard) else $error("unsupported egress answered");

  property p_reserved;
    state == ST_PTAIL && probe_code >= CODE_RSV_LO |=> !reply_valid;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code answered");

  property p_gap;
    accept && state == ST_SEQ1 && numv && seq_seen && session_open
      && rx_word != exp_seq |=> seq_gap;
  endproperty
  a_gap: assert property (p_gap) else $error("order gap not flagged");

  property p_ts_len;
    accept && state == ST_PAYLOAD && !session_streaming && session_open && rx_last
      && ts_cnt != TS_LAST |=> teardown_req;
  endproperty
  a_ts_len: assert property (p_ts_len) else $error("wrong type not torn down");

  property p_frame_end;
    push && session_streaming && item.frame_end && session_open |=> !in_frame;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame left open");

endmodule

// ==== src/pwsf_pkg.sv ====
// Package for the pseudowire sub-layer receive framer.
// Assumes a byte-wide receive stream with a last-byte marker per tunnel payload.
package pwsf_pkg;

  // ----------------------------------------------------------------
  // First and second header byte layout
  // ----------------------------------------------------------------
  localparam int CHECK_BIT = 7;
  localparam int NUMV_BIT  = 6;
  localparam int EXT_HI    = 5;
  localparam int EXT_LO    = 4;
  localparam int SPARE_BIT = 3;
  localparam int TAG_HI    = 2;
  localparam int TAG_LO    = 0;
  localparam int TALLY_HI  = 6;

  localparam logic [1:0] EXT_NONE  = 2'h0;
  localparam logic [1:0] EXT_PROBE = 2'h1;

  // ----------------------------------------------------------------
  // Segment-table entry and transport packet constants
  // ----------------------------------------------------------------
  localparam int ENT_START_BIT = 15;
  localparam int ENT_TAIL_BIT  = 14;
  localparam int ENT_LEN_HI    = 13;
  localparam int MAX_SEGS      = 128;

  localparam logic [7:0]  TS_FIRST  = 8'h00;
  localparam logic [7:0]  TS_PID_HI = 8'h01;
  localparam logic [7:0]  TS_PID_LO = 8'h02;
  localparam logic [7:0]  TS_LAST   = 8'hbb;
  localparam int          PID_MSB   = 4;
  localparam logic [12:0] NULL_PID  = 13'h1fff;

  // ----------------------------------------------------------------
  // Probe codes and buffering
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_IN_REQ = 8'h00;
  localparam logic [7:0] CODE_IN_REP = 8'h01;
  localparam logic [7:0] CODE_EG_REQ = 8'h02;
  localparam logic [7:0] CODE_EG_REP = 8'h03;
  localparam logic [7:0] CODE_RSV_LO = 8'h04;
  localparam int         FIFO_DEPTH  = 8;

  typedef enum logic [3:0] {
    ST_HDR0, ST_HDR1, ST_SEQ0, ST_SEQ1, ST_TBL_HI, ST_TBL_LO,
    ST_PAYLOAD, ST_PCODE, ST_PTXN, ST_PTAIL, ST_DROP
  } pwsf_state_type;

  typedef struct packed {
    logic [7:0] data;
    logic       seg_first;
    logic       seg_last;
    logic       frame_start;
    logic       frame_end;
    logic       null_pkt;
    logic       streaming;
    logic [2:0] tag;
  } pwsf_item_type;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] txn;
    logic [2:0] tag;
  } pwsf_reply_type;

endpackage

// ==== verification/pwsf_core_model.sv ====
// Behavioural model of the sending cable core that feeds the framer's byte port.
// Assumes the bench calls send once per whole tunnel payload, just after a clock edge.
`timescale 1ns/10ps

module pwsf_core_model (
  // Clock
  input  wire logic       mclk,
  // Byte stream toward the framer
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_last
);
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h5a;
    rx_last  = 1'b0;
  end

  // Bytes go out back to back with no stuffing, one payload per call.
  task automatic send(input logic [7:0] pl[$]);
    logic ok;
    for (int i = 0; i < pl.size(); i++) begin
      rx_valid = 1'b1;
      rx_data  = pl[i];
      rx_last  = (i == pl.size() - 1);
      do begin
        @(negedge mclk);
        ok = rx_ready;
        @(posedge mclk);
        #1;
      end while (ok !== 1'b1);
    end
    // A released line shows the inverse of the last byte, so stale data never looks valid.
    rx_valid = 1'b0;
    rx_last  = 1'b0;
    rx_data  = ~rx_data;
  endtask
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the pseudowire sub-layer receive framer.
// Assumes the core model in pwsf_core_model and the design package are compiled first.
`timescale 1ns/10ps

module tb_top;
  import pwsf_pkg::*;
  logic           mclk = 1'b0;
  logic           arst_n = 1'b0;
  logic           session_open = 1'b0;
  logic           session_streaming = 1'b0;
  logic           egress_supported = 1'b0;
  logic           out_ready = 1'b1;
  logic           rx_valid, rx_ready, rx_last, out_valid, reply_valid;
  logic           seq_gap, hdr_drop, frame_err, teardown_req;
  logic [7:0]     rx_data;
  pwsf_item_type  out_item;
  pwsf_reply_type reply;
  pwsf_item_type  iq[$];
  pwsf_reply_type rq[$];
  logic [7:0]     pl[$];
  int             n_gap, n_drop, n_ferr, bad_count, n_tests;

  always #5 mclk = ~mclk;

  pwsf_core_model u_pwsf_core_model (.mclk(mclk), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_last(rx_last));

  pwsf_framer u_pwsf_framer (.mclk(mclk), .arst_n(arst_n), .session_open(session_open),
    .session_streaming(session_streaming), .egress_supported(egress_supported),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last),
    .out_valid(out_valid), .out_ready(out_ready), .out_item(out_item),
    .reply_valid(reply_valid), .reply(reply), .seq_gap(seq_gap), .hdr_drop(hdr_drop),
    .frame_err(frame_err), .teardown_req(teardown_req));

  // Pulses stand one cycle; sampling mid-cycle sees each settled value exactly once.
  always @(negedge mclk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) iq.push_back(out_item);
    if (reply_valid === 1'b1) rq.push_back(reply);
    if (seq_gap === 1'b1) n_gap++;
    if (hdr_drop === 1'b1) n_drop++;
    if (frame_err === 1'b1) n_ferr++;
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // The sink stalls at the start of every payload so the buffer fills and then drains.
  task run(input logic full);
    iq.delete();
    rq.delete();
    n_gap = 0;
    n_drop = 0;
    n_ferr = 0;
    fork
      u_pwsf_core_model.send(pl);
      begin
        out_ready = 1'b0;
        repeat (30) @(posedge mclk);
        #1;
        if (full) chk("rx_ready", 0, rx_ready);
        out_ready = 1'b1;
      end
    join
    repeat (20) @(posedge mclk);
    #1;
  endtask

  // Transport payload of n bytes; a sequence number given by the caller stands in for a random one.
  task ts(input logic [7:0] b0, b1, input logic [15:0] sq, input int n, input logic nul);
    pl = {b0, b1, sq[15:8], sq[7:0]};
    for (int k = 0; k < n; k++)
      pl.push_back(k % 188 == 1 ? (nul ? 8'h1f : 8'h00) :
                   k % 188 == 2 ? (nul ? 8'hff : 8'h00) : k[7:0]);
  endtask

  task probe(input logic [7:0] b0, code, txn);
    pl = {b0, 8'h00, code, txn};
    for (int k = 0; k < 8; k++) pl.push_back(8'ha0 + k[7:0]);
  endtask

  initial begin
    #200000;
    bad_count++;
    results();
  end

  initial begin
    logic [7:0] bad_hdr[4];
    bad_hdr = '{8'hc5, 8'h65, 8'h75, 8'h45};
    repeat (6) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    session_open = 1'b1;
    ts(8'h45, 8'h00, 16'h1234, 376, 1'b1);
    run(1'b1);
    chk("ts_count", 376, iq.size());
    chk("ts_first", 1, iq[0].seg_first);
    chk("ts_tag", 5, iq[10].tag);
    chk("ts_data", 8'h0a, iq[10].data);
    chk("ts_null", 1, iq[375].null_pkt & iq[187].seg_last);
    chk("ts_nogap", 0, n_gap);
    ts(8'h45, 8'h00, 16'h1236, 188, 1'b0);
    run(1'b1);
    chk("gap", 1, n_gap);
    chk("nonnull", 0, iq[187].null_pkt);
    ts(8'h05, 8'h00, 16'h0000, 188, 1'b0);
    run(1'b1);
    chk("unnumbered", 0, n_gap);
    ts(8'h4d, 8'hff, 16'h0001, 188, 1'b0);
    run(1'b1);
    chk("spare_items", 188, iq.size());
    chk("spare_drop", 0, n_drop);
    for (int i = 0; i < 4; i++) begin
      ts(bad_hdr[i], 8'h00, 16'h0002, 188, 1'b0);
      if (i == 3) pl[0][TAG_LO] = 1'b0;
      run(1'b0);
      chk("bad_items", 0, iq.size());
      chk("bad_drop", i < 3, n_drop);
    end
    for (int i = 0; i < 6; i++) begin
      egress_supported = (i != 5);
      probe(8'h15, (i == 5) ? 8'h02 : i[7:0], 8'h30 + i[7:0]);
      run(1'b0);
      chk("reply_n", (i == 0 || i == 2), rq.size());
      if (rq.size() == 1) chk("reply", {i[7:0] + 8'h01, 8'h30 + i[7:0], 3'h5}, rq[0]);
    end
    probe(8'h55, 8'h00, 8'h01);
    run(1'b0);
    chk("numbered_probe", 1, n_drop + rq.size());
    ts(8'h45, 8'h00, 16'h0003, 100, 1'b0);
    run(1'b0);
    chk("teardown", 1, teardown_req);
    session_open = 1'b0;
    ts(8'h45, 8'h00, 16'h0004, 188, 1'b0);
    run(1'b0);
    chk("closed", {1'b0, 1'b1}, {teardown_req, n_drop == 1});
    session_streaming = 1'b1;
    session_open = 1'b1;
    // Only the first and last frame of a PDU are split; the middle PDU holds a bare piece.
    pl = {8'h42, 8'h02, 8'h00, 8'h05, 8'hc0, 8'h02, 8'h80, 8'h03, 8'h11, 8'h12, 8'h21, 8'h22,
          8'h23};
    run(1'b0);
    chk("ps_count", 5, iq.size());
    chk("ps_whole", 3'h7, {iq[0].frame_start, iq[1].frame_end, iq[2].frame_start});
    chk("ps_open", 3'h2, {iq[4].frame_end, iq[4].streaming, iq[4].tag[0]});
    pl = {8'h42, 8'h01, 8'h00, 8'h06, 8'h00, 8'h02, 8'h24, 8'h25};
    run(1'b0);
    pl = {8'h42, 8'h01, 8'h00, 8'h07, 8'h40, 8'h01, 8'h26};
    run(1'b0);
    chk("ps_tail", {1'b1, 1'b0}, {iq[0].frame_end, n_ferr == 1});
    run(1'b0);
    chk("ps_orphan", 1, n_ferr);
    pl = {8'h42, 8'h00, 8'h00, 8'h08, 8'h33};
    run(1'b0);
    chk("ps_zero_tally", 1, n_drop);
    probe(8'h12, 8'h00, 8'h44);
    run(1'b0);
    chk("ps_probe", {8'h01, 8'h44, 3'h2}, rq.size() == 1 ? rq[0] : 19'h0);
    results();
  end
endmodule
